// ===== tape_crc_check_generator.v
`timescale 1ns/1ps
`include "tape_crc_regs.vh"

// What this block does
// - Nine-bit ring, parity to 0, 7 to parity
// - Bits P,0,1,6,7 take data XOR previous
// - Bits 2..5 also XOR bit 7
// - Each update loads the computed value
// - Clear register on load and in gaps
// - Extra zero-data update after last character
// - Readout inverts all bits but 2, 4
// - Check character four positions after data
// - Longitudinal character four later, then gap
// - Track order 5,7,3,P,2,1,0,6,4 kept
// - Extra update on second gap pulse
// - Fourth gap pulse writes check character
// - Counter back at zero clears register
// - No check character without new data since the last gap clear, except in the first gap after reset
module tape_crc_check_generator #(
   parameter W = `CRC_WIDTH
) (
   input  wire         clock,
   input  wire         nrst,
   input  wire         clk_en,
   input  wire         tape_load,
   input  wire         write_step,
   input  wire         gap_start,
   input  wire         gap_in_process,
   input  wire         gap_clock,
   input  wire         file_mark,
   input  wire [W-1:0] track_data,
   output reg  [W-1:0] write_data_r,
   output reg          write_clock_r,
   output reg          longitudinal_enable_r,
   output reg  [W-1:0] check_shift_register
);

   // Every input but nrst and clk_en runs free of clock, so each passes two flip-flops first
   reg [W-1:0] data_s1_r;
   reg [W-1:0] data_s2_r;
   reg         load_s1_r;
   reg         load_s2_r;
   reg         step_s1_r;
   reg         step_s2_r;
   reg         step_d_r;
   reg         gstart_s1_r;
   reg         gstart_s2_r;
   reg         gstart_d_r;
   reg         gip_s1_r;
   reg         gip_s2_r;
   reg         gclk_s1_r;
   reg         gclk_s2_r;
   reg         gclk_d_r;
   reg         fmark_s1_r;
   reg         fmark_s2_r;
   reg         fmark_d_r;

   // Data is sampled a cycle after it settles, so skew between lanes is harmless
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         data_s1_r <= {W{1'b0}};
         data_s2_r <= {W{1'b0}};
      end else if (clk_en) begin
         data_s1_r <= track_data;
         data_s2_r <= data_s1_r;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         load_s1_r <= 1'b0;
         load_s2_r <= 1'b0;
      end else if (clk_en) begin
         load_s1_r <= tape_load;
         load_s2_r <= load_s1_r;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         step_s1_r <= 1'b0;
         step_s2_r <= 1'b0;
         step_d_r  <= 1'b0;
      end else if (clk_en) begin
         step_s1_r <= write_step;
         step_s2_r <= step_s1_r;
         step_d_r  <= step_s2_r;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gstart_s1_r <= 1'b0;
         gstart_s2_r <= 1'b0;
         gstart_d_r  <= 1'b0;
      end else if (clk_en) begin
         gstart_s1_r <= gap_start;
         gstart_s2_r <= gstart_s1_r;
         gstart_d_r  <= gstart_s2_r;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gip_s1_r <= 1'b0;
         gip_s2_r <= 1'b0;
      end else if (clk_en) begin
         gip_s1_r <= gap_in_process;
         gip_s2_r <= gip_s1_r;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gclk_s1_r <= 1'b0;
         gclk_s2_r <= 1'b0;
         gclk_d_r  <= 1'b0;
      end else if (clk_en) begin
         gclk_s1_r <= gap_clock;
         gclk_s2_r <= gclk_s1_r;
         gclk_d_r  <= gclk_s2_r;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         fmark_s1_r <= 1'b0;
         fmark_s2_r <= 1'b0;
         fmark_d_r  <= 1'b0;
      end else if (clk_en) begin
         fmark_s1_r <= file_mark;
         fmark_s2_r <= fmark_s1_r;
         fmark_d_r  <= fmark_s2_r;
      end
   end

   // Edge detectors rest low after reset, the idle level of every pin
   wire load_lvl  = load_s2_r;
   wire in_gap    = gip_s2_r;
   wire step_p    = step_s2_r & ~step_d_r;
   wire gstart_p  = gstart_s2_r & ~gstart_d_r;
   wire gclk_p    = gclk_s2_r & ~gclk_d_r & in_gap;
   wire fmark_p   = fmark_s2_r & ~fmark_d_r;
   // Steps inside a gap are ignored; the stepper is busy spacing tape
   wire data_step = step_p & ~in_gap;

   // One update of the ring; bit index W-1 is parity
   function [W-1:0] crc_next;
      input [W-1:0] cur;
      input [W-1:0] din;
      integer i;
      reg fb;
      begin
         fb = cur[`CRC_BIT7];
         crc_next[0]        = din[0] ^ cur[`CRC_PAR];
         crc_next[`CRC_PAR] = din[`CRC_PAR] ^ fb;
         for (i = 1; i < 8; i = i + 1) begin
            if (i >= 2 && i <= 5)
               crc_next[i] = din[i] ^ cur[i-1] ^ fb;
            else
               crc_next[i] = din[i] ^ cur[i-1];
         end
      end
   endfunction

   // Readout polarity per lane: bits 2 and 4 leave straight, all others complemented
   localparam [W-1:0] INV_MASK = `CRC_INV_MASK;
   wire [W-1:0] readout;
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : lane
         assign readout[g] = check_shift_register[g] ^ INV_MASK[g];
      end
   endgenerate

   // Gap sequencing state
   reg         primer_r;
   reg [1:0]   gap_cnt_r;
   reg         inhibit_r;
   reg         fm_pend_r;
   reg         seen_gap_r;

   reg         primer_nxt;
   reg [1:0]   gap_cnt_nxt;
   reg         inhibit_nxt;
   reg         fm_pend_nxt;
   reg         seen_gap_nxt;
   reg [W-1:0] crc_nxt;
   reg [W-1:0] write_data_nxt;
   reg         write_clock_nxt;
   reg         lcc_enable_nxt;

   wire [W-1:0] gated_data = in_gap ? {W{1'b0}} : data_s2_r;
   wire         counting   = primer_r | (gap_cnt_r != `GAP_T_ZERO);
   wire         at_shift   = gclk_p & counting & (gap_cnt_r == `GAP_T_SHIFT);
   wire         at_read    = gclk_p & counting & (gap_cnt_r == `GAP_T_READ);
   wire         read_ok    = at_read & ~inhibit_r;
   // Primer masks the zero count at gap start so the clear is not premature
   wire         at_zero    = gclk_p & ~primer_r & (gap_cnt_r == `GAP_T_ZERO) & seen_gap_r;

   always @* begin
      primer_nxt   = primer_r;
      seen_gap_nxt = seen_gap_r;
      if (gstart_p) begin
         primer_nxt   = 1'b1;
         seen_gap_nxt = 1'b1;
      end else if (fm_pend_r & gclk_p & ~counting) begin
         // A file mark restarts the count once, on the next gap pulse after the count has come to rest
         primer_nxt = 1'b1;
      end else if (gclk_p) begin
         primer_nxt = 1'b0;
      end
   end

   // The two-bit count wraps to zero after the readout and then rests
   always @* begin
      gap_cnt_nxt = gap_cnt_r;
      if (gclk_p & counting)
         gap_cnt_nxt = gap_cnt_r + 2'h1;
   end

   always @* begin
      inhibit_nxt = inhibit_r;
      if (at_zero)
         inhibit_nxt = 1'b1;
      else if (data_step)
         inhibit_nxt = 1'b0;
   end

   always @* begin
      fm_pend_nxt = fm_pend_r;
      if (fmark_p)
         fm_pend_nxt = 1'b1;
      else if (at_read)
         fm_pend_nxt = 1'b0;
   end

   // Clear outranks any update, so a load during writing always leaves zero
   always @* begin
      crc_nxt = check_shift_register;
      if (load_lvl | at_zero)
         crc_nxt = {W{1'b0}};
      else if (data_step)
         crc_nxt = crc_next(check_shift_register, gated_data);
      else if (at_shift)
         crc_nxt = crc_next(check_shift_register, {W{1'b0}});
   end

   always @* begin
      write_data_nxt  = {W{1'b0}};
      write_clock_nxt = 1'b0;
      if (data_step) begin
         write_data_nxt  = gated_data;
         write_clock_nxt = 1'b1;
      end else if (read_ok) begin
         // Track order is fixed by the write amplifier wiring, so bit lanes map straight
         write_data_nxt  = readout;
         write_clock_nxt = 1'b1;
      end
   end

   // Longitudinal writer held off for the first four gap pulses
   always @* begin
      lcc_enable_nxt = ~(in_gap & counting);
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         primer_r   <= 1'b0;
         gap_cnt_r  <= 2'h0;
         inhibit_r  <= 1'b0;
         fm_pend_r  <= 1'b0;
         seen_gap_r <= 1'b0;
      end else if (clk_en) begin
         primer_r   <= primer_nxt;
         gap_cnt_r  <= gap_cnt_nxt;
         inhibit_r  <= inhibit_nxt;
         fm_pend_r  <= fm_pend_nxt;
         seen_gap_r <= seen_gap_nxt;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         check_shift_register  <= {W{1'b0}};
         write_data_r          <= {W{1'b0}};
         write_clock_r         <= 1'b0;
         longitudinal_enable_r <= 1'b1;
      end else if (clk_en) begin
         check_shift_register  <= crc_nxt;
         write_data_r          <= write_data_nxt;
         write_clock_r         <= write_clock_nxt;
         longitudinal_enable_r <= lcc_enable_nxt;
      end
   end

endmodule

// ===== tape_crc_regs.vh
`ifndef TAPE_CRC_REGS_VH
`define TAPE_CRC_REGS_VH

// Check register bit positions; parity sits above data bit 7
`define CRC_WIDTH       9
`define CRC_BIT7        7
`define CRC_PAR         8
// Readout polarity: ones mark bits that are complemented (all but 2 and 4)
`define CRC_INV_MASK    9'h1eb
// Gap timing counts (gap clock pulse index minus one)
`define GAP_T_SHIFT     2'h1
`define GAP_T_READ      2'h3
`define GAP_T_ZERO      2'h0
// Character spacing between check characters
`define CHECK_SPACING   4
// Least gap length in thousandths of an inch
`define GAP_MIN_MILS    600

`endif

// ===== tape_data_source.sv
`timescale 1ns/1ps
module tape_data_source (input wire clock, output reg write_step, gap_start, gap_in_process, gap_clock, tape_load,
   output reg [8:0] track_data);
   initial {write_step, gap_start, gap_in_process, gap_clock, tape_load, track_data} = 0;
   task wt(input int n); repeat (n) @(negedge clock); endtask
   // Data settles before the step edge; once released the lines show the inverse
   task step(input [8:0] d);
      track_data = d; wt(1); write_step = 1; wt(6);
      write_step = 0; track_data = ~d; wt(6);
   endtask
   task gap(input int n);
      gap_start = 1; gap_in_process = 1; wt(6);
      repeat (n) begin gap_clock = 1; wt(5); gap_clock = 0; wt(5); end
      gap_start = 0; gap_in_process = 0; wt(6);
   endtask
endmodule

// ===== tape_crc_properties.sv
`timescale 1ns/1ps
`include "tape_crc_regs.vh"
module tape_crc_properties #(parameter W = 9) (
   input wire clock, nrst, clk_en, tape_load, gap_in_process, write_clock_r, longitudinal_enable_r,
   input wire [W-1:0] write_data_r, check_shift_register);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   wire [W-1:0] crc = check_shift_register;
   wire ck = write_clock_r && gap_in_process;
   function [W-1:0] nxt(input [W-1:0] c, x); nxt = {c[7:0], c[8]} ^ x ^ ({W{c[7]}} & 9'h03c); endfunction
   pulse_one_a: assert property (write_clock_r |=> !write_clock_r) else $error("long write clock");
   data_idle_a: assert property (!write_clock_r |-> write_data_r == 0) else $error("data off pulse");
   load_clear_a: assert property (tape_load [*5] |-> crc == 0) else $error("load kept register");
   step_update_a: assert property (write_clock_r && !gap_in_process |-> crc == nxt($past(crc), write_data_r))
      else $error("bad update");
   check_value_a: assert property (ck |-> write_data_r == (crc ^ `CRC_INV_MASK)) else $error("bad check");
   lcc_hold_a: assert property (ck |-> !longitudinal_enable_r) else $error("lcc not held");
   gap_clear_a: assert property (ck |-> ##[1:40] crc == 0) else $error("no clear");
   freeze_a: assert property (!clk_en |=> $stable(crc)) else $error("moved while frozen");
endmodule
bind tape_crc_check_generator tape_crc_properties #(.W(W)) tape_crc_properties_i (.clock, .nrst, .clk_en,
   .tape_load, .gap_in_process, .write_clock_r, .longitudinal_enable_r, .write_data_r, .check_shift_register);

// ===== tape_crc_check_generator_tb.sv
`timescale 1ns/1ps
`include "tape_crc_regs.vh"
module tape_crc_check_generator_tb;
   reg clock = 0, nrst = 0, clk_en = 1;
   wire write_step, gap_start, gap_in_process, gap_clock, tape_load, write_clock_r, longitudinal_enable_r;
   wire [8:0] track_data, write_data_r, check_shift_register;
   reg [8:0] crc, d, last, lfsr = 9'h047;
   int error_cnt = 0, tests_run = 0, pulses;
   tape_data_source tape_data_source_i (.clock, .write_step, .gap_start, .gap_in_process, .gap_clock, .tape_load,
      .track_data);
   tape_crc_check_generator tape_crc_check_generator_i (.clock, .nrst, .clk_en, .tape_load, .write_step, .gap_start,
      .gap_in_process, .gap_clock, .file_mark(1'b0), .track_data, .write_data_r, .write_clock_r,
      .longitudinal_enable_r, .check_shift_register);
   function [8:0] nxt(input [8:0] c, x); nxt = {c[7:0], c[8]} ^ x ^ ({9{c[7]}} & 9'h03c); endfunction
   function [8:0] rnd(input [8:0] s); rnd = {s[7:0], s[8] ^ s[4]}; endfunction
   always #4 clock = ~clock;
   always @(posedge clock) if (write_clock_r) begin
      pulses <= pulses + 1;
      last <= write_data_r;
   end
   task chk(input string n, input [8:0] e, s);
      tests_run++;
      if (s !== e) begin error_cnt++; $display("mismatch %s expected %h seen %h", n, e, s); end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #100us;
      error_cnt++;
      end_sim;
   end
   initial begin
      repeat (20) @(negedge clock);
      nrst = 1;
      chk("reset", 9'h000, check_shift_register);
      for (int r = 0; r < 4; r++) begin
         crc = 0;
         repeat (lfsr[2:0] + 1) begin
            lfsr = rnd(lfsr);
            d = r ? lfsr : 9'h1ff;
            tape_data_source_i.step(d);
            crc = nxt(crc, d);
            chk("register", crc, check_shift_register);
         end
         pulses = 0;
         tape_data_source_i.gap(6);
         chk("check char", nxt(crc, 9'h000) ^ `CRC_INV_MASK, last);
         chk("writes", 9'h001, 9'(pulses));
         chk("cleared", 9'h000, check_shift_register);
         $display("record %0d done", r);
      end
      pulses = 0;
      tape_data_source_i.gap(6);
      chk("idle gap", 9'h000, 9'(pulses));
      clk_en = 0;
      tape_data_source_i.step(9'h0a5);
      clk_en = 1;
      chk("frozen", 9'h000, check_shift_register);
      tape_data_source_i.step(9'h0a5);
      chk("first char", 9'h0a5, check_shift_register);
      tape_data_source_i.tape_load = 1;
      repeat (8) @(negedge clock);
      chk("loaded", 9'h000, check_shift_register);
      tape_data_source_i.tape_load = 0;
      $display("gap and load tests done");
      end_sim;
   end
endmodule
